// [hdl/boot_map_pkg.sv]
// constants, field layouts and types for the boot and program memory map
// assumes a 14-bit program address bus and 24-bit external data bus
package boot_map_pkg;
	localparam int ADDR_W      = 14;
	localparam int DATA_W      = 24;
	localparam int REG_W       = 16;
	localparam int RAM_WORDS   = 2048;
	localparam int PAGE_BITS   = 3;
	localparam int PAGE_BYTE_W = 13;
	localparam int WAIT_W      = 3;
	localparam int SYNC_CYC    = 2;
	localparam int WORD_BYTES  = 3;

	localparam logic [ADDR_W-1:0] RAM_LO_BASE  = 14'h0000;
	localparam logic [ADDR_W-1:0] RAM_HI_BASE  = 14'h3800;
	localparam logic [ADDR_W-1:0] RAM_LO_END   = 14'h07ff;
	localparam logic [ADDR_W-1:0] ROM_LO       = 14'h0800;
	localparam logic [ADDR_W-1:0] ROM_HI       = 14'h27ff;
	localparam logic [ADDR_W-1:0] START_RAM    = 14'h0000;
	localparam logic [ADDR_W-1:0] START_ROM    = 14'h0800;

	localparam logic [ADDR_W-1:0] WAIT_CTRL_ADDR = 14'h3ffe;
	localparam logic [ADDR_W-1:0] SYS_CTRL_ADDR  = 14'h3fff;

	// wait-state control: rom enable on top, zone wait fields below
	localparam int                ROM_EN_BIT     = 15;
	localparam logic [14:0]       DWAIT_RST      = 15'h7fff;
	// system control: page, force, boot wait, program wait
	localparam int                PAGE_LSB       = 0;
	localparam int                FORCE_BIT      = 3;
	localparam int                BWAIT_LSB      = 4;
	localparam int                PWAIT_LSB      = 7;
	localparam logic [9:0]        SYS_CTRL_RST   = 10'h3f0;

	typedef enum logic [1:0] {
		TGT_RAM = 2'b00,
		TGT_ROM = 2'b01,
		TGT_EXT = 2'b10
	} pm_target_t;
endpackage

// [hdl/byte_fetch_if.sv]
// request/answer carrier between the map controller and the fetch engine
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface byte_fetch_if;
	logic        req;
	logic        is_boot;
	logic [15:0] addr;
	logic [2:0]  wait_states;
	logic        done;
	logic [23:0] data;
	modport ctrl (output req, is_boot, addr, wait_states, input done, data);
	modport eng  (input req, is_boot, addr, wait_states, output done, data);
endinterface
`default_nettype wire

// [hdl/ext_fetch_engine.sv]
// one external read with programmable wait states, boot or program space
// assumes the data bus pins are asynchronous and get a two-stage sync
`timescale 1ns/1ps
`default_nettype none
module ext_fetch_engine
	import boot_map_pkg::*;
(
	// clock and reset
	input  wire logic              clock_in,
	input  wire logic              rst_in,
	// controller side
	byte_fetch_if.eng              f,
	// external bus
	input  wire logic [DATA_W-1:0] data_in,
	output logic [ADDR_W-1:0]      addr_out,
	output logic [1:0]             data_msb_out,
	output logic                   data_msb_oe_out,
	output logic                   rd_n_out,
	output logic                   boot_memory_select_n_out,
	output logic                   program_memory_select_n_out
);
	typedef struct packed {
		logic [DATA_W-1:0] sync0;
		logic [DATA_W-1:0] sync1;
		logic              busy;
		logic              boot;
		logic [15:0]       addr;
		logic [3:0]        cnt;
		logic              done;
		logic [DATA_W-1:0] data;
	} fetch_state_t;

	fetch_state_t s_r, s_nxt;

	always_comb begin
		s_nxt       = s_r;
		s_nxt.sync0 = data_in;
		s_nxt.sync1 = s_r.sync0;
		s_nxt.done  = 1'b0;
		if (!s_r.busy && f.req) begin
			s_nxt.busy = 1'b1;
			s_nxt.boot = f.is_boot;
			s_nxt.addr = f.addr;
			// strobe spans the wait states plus sync latency
			s_nxt.cnt  = 4'(f.wait_states) + 4'(SYNC_CYC);
		end else if (s_r.busy) begin
			if (s_r.cnt == 4'h0) begin
				s_nxt.busy = 1'b0;
				s_nxt.done = 1'b1;
				s_nxt.data = s_r.sync1;
			end else begin
				s_nxt.cnt = s_r.cnt - 4'h1;
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign f.done                      = s_r.done;
	assign f.data                      = s_r.data;
	assign addr_out                    = s_r.addr[ADDR_W-1:0];
	assign rd_n_out                    = !s_r.busy;
	assign boot_memory_select_n_out    = !(s_r.busy && s_r.boot);
	assign program_memory_select_n_out = !(s_r.busy && !s_r.boot);
	// top boot address bits ride on the two top data lines
	assign data_msb_out                = s_r.addr[15:14];
	assign data_msb_oe_out             = s_r.busy && s_r.boot;

	logic [3:0] strobe_len_r;
	logic [2:0] wait_seen_r;
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			strobe_len_r <= '0;
			wait_seen_r  <= '0;
		end else if (!s_r.busy && f.req) begin
			strobe_len_r <= '0;
			wait_seen_r  <= f.wait_states;
		end else if (s_r.busy) begin
			strobe_len_r <= strobe_len_r + 4'h1;
		end
	end

	chk_strobe_qualified: assert property (@(posedge clock_in) disable iff (rst_in)
		!rd_n_out |-> (boot_memory_select_n_out != program_memory_select_n_out))
		else $error("read strobe without a single memory select");
	chk_strobe_wait_length: assert property (@(posedge clock_in) disable iff (rst_in)
		$rose(rd_n_out) |-> strobe_len_r == 4'(wait_seen_r) + 4'(SYNC_CYC) + 4'h1)
		else $error("strobe length does not match wait states");
	chk_page_msb_drive: assert property (@(posedge clock_in) disable iff (rst_in)
		!boot_memory_select_n_out && $past(!boot_memory_select_n_out)
		|-> data_msb_oe_out && $stable(data_msb_out) && $stable(addr_out))
		else $error("boot page msbs not held on data lines");
endmodule
`default_nettype wire

// [hdl/boot_and_program_memory_map.sv]
// start-up map, boot loader and program memory decode for the processor
// assumes the core drives its data-memory register port and pm address
// on this clock; mode pins and bus request are asynchronous
`timescale 1ns/1ps
`default_nettype none
module boot_and_program_memory_map
	import boot_map_pkg::*;
#(
	parameter int BOOT_WORDS = RAM_WORDS
)(
	// clock and reset
	input  wire logic              clock_in,
	input  wire logic              rst_in,
	// mode and bus request pins
	input  wire logic              memory_map_select_in,
	input  wire logic              boot_source_select_in,
	input  wire logic              external_bus_request_n_in,
	// data-memory register port
	input  wire logic [ADDR_W-1:0] dm_addr_in,
	input  wire logic              dm_we_in,
	input  wire logic              dm_re_in,
	input  wire logic [REG_W-1:0]  dm_wdata_in,
	output logic [REG_W-1:0]       dm_rdata_out,
	// program memory access from the core
	input  wire logic [ADDR_W-1:0] pm_addr_in,
	input  wire logic              pm_req_in,
	output pm_target_t             pm_target_out,
	output logic                   pm_ack_out,
	output logic [DATA_W-1:0]      pm_rdata_out,
	// internal RAM load port and core control
	output logic                   ram_we_out,
	output logic [10:0]            ram_addr_out,
	output logic [DATA_W-1:0]      ram_wdata_out,
	output logic                   core_run_out,
	output logic [ADDR_W-1:0]      start_addr_out,
	// host port boot
	output logic                   host_boot_req_out,
	input  wire logic              host_boot_done_in,
	// external bus
	input  wire logic [DATA_W-1:0] data_in,
	output logic [ADDR_W-1:0]      addr_out,
	output logic [1:0]             data_msb_out,
	output logic                   data_msb_oe_out,
	output logic                   rd_n_out,
	output logic                   boot_memory_select_n_out,
	output logic                   program_memory_select_n_out
);
	typedef enum logic [2:0] {
		ST_STRAP   = 3'b000,
		ST_DECIDE  = 3'b001,
		ST_BOOT_RQ = 3'b010,
		ST_BOOT_WT = 3'b011,
		ST_HOST    = 3'b100,
		ST_RUN     = 3'b101,
		ST_PM_WT   = 3'b110
	} map_state_t;

	typedef struct packed {
		map_state_t        state;
		logic [1:0]        memory_map_select_sync;
		logic [1:0]        boot_source_select_sync;
		logic [1:0]        br_sync;
		logic [1:0]        strap_cnt;
		logic              memory_map_select;
		logic              boot_source_select;
		logic              rom_en;
		logic [14:0]       dwait;
		logic [9:0]        sys_ctrl;
		logic [1:0]        byte_idx;
		logic [PAGE_BYTE_W-1:0] byte_ptr;
		logic [10:0]       word_cnt;
		logic [15:0]       asm_bytes;
		logic              ram_we;
		logic [10:0]       ram_addr;
		logic [DATA_W-1:0] ram_wdata;
		logic              req;
		logic              req_boot;
		logic [15:0]       req_addr;
		logic [2:0]        req_wait;
		logic              pm_ack;
		logic [DATA_W-1:0] pm_rdata;
		pm_target_t        pm_target;
		logic [REG_W-1:0]  dm_rdata;
		logic              run;
		logic [ADDR_W-1:0] start_addr;
	} map_regs_t;

	localparam logic [10:0] LAST_WORD = 11'(BOOT_WORDS - 1);

	map_regs_t   s_r, s_nxt;
	byte_fetch_if fif ();

	logic       bus_req;
	logic [7:0] boot_byte;
	logic [2:0] boot_page;
	logic       force_boot;
	pm_target_t decode;

	assign bus_req    = !s_r.br_sync[1];
	assign boot_byte  = fif.data[15:8];
	assign boot_page  = s_r.sys_ctrl[PAGE_LSB +: PAGE_BITS];
	assign force_boot = s_r.sys_ctrl[FORCE_BIT];

	always_comb begin
		if (s_r.rom_en && pm_addr_in >= ROM_LO && pm_addr_in <= ROM_HI) begin
			decode = TGT_ROM;
		end else if (!s_r.memory_map_select && pm_addr_in <= RAM_LO_END) begin
			decode = TGT_RAM;
		end else if (s_r.memory_map_select && pm_addr_in >= RAM_HI_BASE) begin
			decode = TGT_RAM;
		end else begin
			decode = TGT_EXT;
		end
	end

	always_comb begin
		s_nxt            = s_r;
		// first stage feeds only the second stage
		s_nxt.memory_map_select_sync  = {s_r.memory_map_select_sync[0], memory_map_select_in};
		s_nxt.boot_source_select_sync = {s_r.boot_source_select_sync[0], boot_source_select_in};
		s_nxt.br_sync    = {s_r.br_sync[0], external_bus_request_n_in};
		s_nxt.pm_target  = decode;
		s_nxt.ram_we     = 1'b0;
		s_nxt.req        = 1'b0;
		s_nxt.pm_ack     = 1'b0;

		if (dm_re_in) begin
			if (dm_addr_in == WAIT_CTRL_ADDR) begin
				s_nxt.dm_rdata = {s_r.rom_en, s_r.dwait};
			end else if (dm_addr_in == SYS_CTRL_ADDR) begin
				s_nxt.dm_rdata = {6'h00, s_r.sys_ctrl};
			end else begin
				s_nxt.dm_rdata = '0;
			end
		end

		case (s_r.state)
			ST_STRAP: begin
				s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
				if (s_r.strap_cnt == 2'(SYNC_CYC)) begin
					s_nxt.memory_map_select   = s_r.memory_map_select_sync[1];
					s_nxt.boot_source_select  = s_r.boot_source_select_sync[1];
					s_nxt.rom_en = s_r.memory_map_select_sync[1] && s_r.boot_source_select_sync[1];
					s_nxt.state  = ST_DECIDE;
				end
			end
			ST_DECIDE: begin
				s_nxt.byte_idx = '0;
				s_nxt.byte_ptr = '0;
				s_nxt.word_cnt = '0;
				if (s_r.memory_map_select && !force_boot) begin
					s_nxt.run        = 1'b1;
					s_nxt.start_addr = s_r.boot_source_select ? START_ROM : RAM_LO_BASE;
					s_nxt.state      = ST_RUN;
				end else if (!bus_req) begin
					s_nxt.start_addr = START_RAM;
					s_nxt.state      = s_r.boot_source_select ? ST_HOST : ST_BOOT_RQ;
				end
			end
			ST_BOOT_RQ: begin
				if (!bus_req) begin
					s_nxt.req      = 1'b1;
					s_nxt.req_boot = 1'b1;
					s_nxt.req_addr = {boot_page, s_r.byte_ptr};
					s_nxt.req_wait = s_r.sys_ctrl[BWAIT_LSB +: WAIT_W];
					s_nxt.state    = ST_BOOT_WT;
				end
			end
			ST_BOOT_WT: begin
				if (fif.done) begin
					s_nxt.byte_ptr  = s_r.byte_ptr + 13'h1;
					s_nxt.asm_bytes = {s_r.asm_bytes[7:0], boot_byte};
					s_nxt.state     = ST_BOOT_RQ;
					if (s_r.byte_idx == 2'(WORD_BYTES - 1)) begin
						s_nxt.byte_idx  = '0;
						s_nxt.ram_we    = 1'b1;
						s_nxt.ram_addr  = s_r.word_cnt;
						s_nxt.ram_wdata = {s_r.asm_bytes, boot_byte};
						s_nxt.word_cnt  = s_r.word_cnt + 11'h1;
						if (s_r.word_cnt == LAST_WORD) begin
							s_nxt.sys_ctrl[FORCE_BIT] = 1'b0;
							s_nxt.run                 = 1'b1;
							s_nxt.state               = ST_RUN;
						end
					end else begin
						s_nxt.byte_idx = s_r.byte_idx + 2'h1;
					end
				end
			end
			ST_HOST: begin
				if (host_boot_done_in) begin
					s_nxt.sys_ctrl[FORCE_BIT] = 1'b0;
					s_nxt.run                 = 1'b1;
					s_nxt.state               = ST_RUN;
				end
			end
			ST_RUN: begin
				if (force_boot) begin
					s_nxt.run   = 1'b0;
					s_nxt.state = ST_DECIDE;
				end else if (pm_req_in && decode == TGT_EXT && !bus_req) begin
					s_nxt.req      = 1'b1;
					s_nxt.req_boot = 1'b0;
					s_nxt.req_addr = {2'b00, pm_addr_in};
					s_nxt.req_wait = s_r.sys_ctrl[PWAIT_LSB +: WAIT_W];
					s_nxt.state    = ST_PM_WT;
				end
			end
			ST_PM_WT: begin
				if (fif.done) begin
					s_nxt.pm_ack   = 1'b1;
					s_nxt.pm_rdata = fif.data;
					s_nxt.state    = ST_RUN;
				end
			end
			default: begin
				s_nxt.state = ST_STRAP;
			end
		endcase

		// software writes last, so a force set beats the loader's clear
		if (dm_we_in && dm_addr_in == WAIT_CTRL_ADDR) begin
			s_nxt.rom_en = dm_wdata_in[ROM_EN_BIT];
			s_nxt.dwait  = dm_wdata_in[14:0];
		end
		if (dm_we_in && dm_addr_in == SYS_CTRL_ADDR) begin
			s_nxt.sys_ctrl = dm_wdata_in[9:0];
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			s_r          <= '0;
			s_r.state    <= ST_STRAP;
			s_r.br_sync  <= 2'b11;
			s_r.dwait    <= DWAIT_RST;
			s_r.sys_ctrl <= SYS_CTRL_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign fif.req         = s_r.req;
	assign fif.is_boot     = s_r.req_boot;
	assign fif.addr        = s_r.req_addr;
	assign fif.wait_states = s_r.req_wait;

	ext_fetch_engine u_fetch (
		.clock_in                    (clock_in),
		.rst_in                      (rst_in),
		.f                           (fif.eng),
		.data_in                     (data_in),
		.addr_out                    (addr_out),
		.data_msb_out                (data_msb_out),
		.data_msb_oe_out             (data_msb_oe_out),
		.rd_n_out                    (rd_n_out),
		.boot_memory_select_n_out    (boot_memory_select_n_out),
		.program_memory_select_n_out (program_memory_select_n_out)
	);

	assign dm_rdata_out      = s_r.dm_rdata;
	assign pm_target_out     = s_r.pm_target;
	assign pm_ack_out        = s_r.pm_ack;
	assign pm_rdata_out      = s_r.pm_rdata;
	assign ram_we_out        = s_r.ram_we;
	assign ram_addr_out      = s_r.ram_addr;
	assign ram_wdata_out     = s_r.ram_wdata;
	assign core_run_out      = s_r.run;
	assign start_addr_out    = s_r.start_addr;
	assign host_boot_req_out = (s_r.state == ST_HOST);

	chk_rom_reset_value: assert property (@(posedge clock_in) disable iff (rst_in)
		$past(s_r.state) == ST_STRAP && s_r.state == ST_DECIDE
		|-> s_r.rom_en == (s_r.memory_map_select && s_r.boot_source_select))
		else $error("rom enable reset value wrong");
	chk_rom_window_route: assert property (@(posedge clock_in) disable iff (rst_in)
		(pm_addr_in >= ROM_LO && pm_addr_in <= ROM_HI)
		|=> pm_target_out == ($past(s_r.rom_en) ? TGT_ROM : TGT_EXT))
		else $error("rom window routed wrongly");
	chk_ram_low_map: assert property (@(posedge clock_in) disable iff (rst_in)
		!s_r.memory_map_select && pm_addr_in < ROM_LO |=> pm_target_out == TGT_RAM)
		else $error("low internal RAM not decoded");
	chk_ram_high_map: assert property (@(posedge clock_in) disable iff (rst_in)
		s_r.memory_map_select && !s_r.rom_en && pm_addr_in < ROM_LO |=> pm_target_out == TGT_EXT)
		else $error("map high: low addresses not external");
	chk_no_boot_mapped: assert property (@(posedge clock_in) disable iff (rst_in)
		s_r.state == ST_DECIDE && s_r.memory_map_select && !force_boot |=> s_r.state == ST_RUN && s_r.run)
		else $error("boot attempted with map pin high");
	chk_hold_core_boot: assert property (@(posedge clock_in) disable iff (rst_in)
		(s_r.state == ST_BOOT_RQ || s_r.state == ST_BOOT_WT || s_r.state == ST_HOST)
		|-> !core_run_out)
		else $error("core running during boot");
	chk_word_sequence: assert property (@(posedge clock_in) disable iff (rst_in)
		ram_we_out |-> ram_addr_out == s_r.word_cnt - 11'h1)
		else $error("boot word written out of order");
	chk_start_vector: assert property (@(posedge clock_in) disable iff (rst_in)
		$rose(core_run_out) |-> start_addr_out == ((s_r.memory_map_select && s_r.boot_source_select) ? START_ROM : START_RAM))
		else $error("wrong start address");
	chk_bus_request_wait: assert property (@(posedge clock_in) disable iff (rst_in)
		s_r.state == ST_DECIDE && bus_req |=> s_r.state != ST_BOOT_RQ && s_r.state != ST_HOST)
		else $error("boot began under bus request");

	cov_eprom_boot: cover property (@(posedge clock_in) disable iff (rst_in)
		s_r.state == ST_BOOT_WT && s_r.word_cnt == LAST_WORD ##[1:40] core_run_out);
	cov_host_boot: cover property (@(posedge clock_in) disable iff (rst_in)
		host_boot_req_out ##1 !host_boot_req_out);
	cov_rom_standalone: cover property (@(posedge clock_in) disable iff (rst_in)
		$rose(core_run_out) && start_addr_out == START_ROM);
	cov_pm_external: cover property (@(posedge clock_in) disable iff (rst_in) pm_ack_out);
endmodule
`default_nettype wire

// [tb/boot_mem_model.sv]
// byte-wide boot memory and 24-bit program memory on the external bus
// assumes the bench merges the device-driven top data lines itself
`timescale 1ns/1ps
`default_nettype none
module boot_mem_model
	import boot_map_pkg::*;
(
	// clock
	input  wire logic              clock_in,
	// device bus
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [1:0]        data_msb_in,
	input  wire logic              rd_n_in,
	input  wire logic              boot_memory_select_n_in,
	input  wire logic              program_memory_select_n_in,
	output logic [DATA_W-1:0]      data_out
);
	logic [DATA_W-1:0] last_r = '0;
	logic              on;
	function automatic logic [7:0] byte_of(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h96;
	endfunction
	function automatic logic [23:0] word_of(input logic [13:0] a);
		return {a[13:6] ^ 8'h5a, 2'b01, a};
	endfunction
	// strobe alone never opens the memory
	assign on = !rd_n_in && (!boot_memory_select_n_in || !program_memory_select_n_in);
	// released lines keep changing so a stale capture shows up
	always_comb begin
		data_out = ~last_r;
		if (on && !boot_memory_select_n_in)
			data_out[15:8] = byte_of({data_msb_in, addr_in});
		else if (on)
			data_out = word_of(addr_in);
	end
	always_ff @(posedge clock_in) last_r <= data_out;
endmodule
`default_nettype wire

// [tb/boot_and_program_memory_map_tb.sv]
// self-checking bench for the boot and program memory map
// assumes the boot memory model answers on the external bus
`timescale 1ns/1ps
`default_nettype none
module boot_and_program_memory_map_tb;
	import boot_map_pkg::*;
	localparam int BW = 4;
	logic clock_in = 0, rst_in = 1, mm = 0, bm = 0, br_n = 1, we = 0, re = 0, req = 0, hd = 0;
	logic [ADDR_W-1:0] dma = '0, pma = '0, addr_out, start_addr_out;
	logic [REG_W-1:0] wd = '0, rdata;
	logic [DATA_W-1:0] data_in, mem_data, pm_rdata, ram_wdata;
	logic [10:0] ram_addr;
	logic [1:0] msb;
	logic oe, rd_n, bms_n, pms_n, ack, ram_we, run, host_req;
	pm_target_t tgt;
	int n_mismatch = 0, n_tests = 0, cnt = 0, last_len = 0, n_we = 0, n_bms = 0;
	logic [3:0] seen_hi;
	logic [23:0] exp_q[$];
	logic [7:0] rnd = 8'd91;
	initial forever #5 clock_in = ~clock_in;
	assign data_in = {oe ? msb : mem_data[23:22], mem_data[21:0]};
	boot_and_program_memory_map #(.BOOT_WORDS(BW)) uut (.clock_in(clock_in), .rst_in(rst_in),
		.memory_map_select_in(mm), .boot_source_select_in(bm), .external_bus_request_n_in(br_n),
		.dm_addr_in(dma), .dm_we_in(we), .dm_re_in(re), .dm_wdata_in(wd), .dm_rdata_out(rdata),
		.pm_addr_in(pma), .pm_req_in(req), .pm_target_out(tgt), .pm_ack_out(ack),
		.pm_rdata_out(pm_rdata), .ram_we_out(ram_we), .ram_addr_out(ram_addr),
		.ram_wdata_out(ram_wdata), .core_run_out(run), .start_addr_out(start_addr_out),
		.host_boot_req_out(host_req), .host_boot_done_in(hd), .data_in(data_in),
		.addr_out(addr_out), .data_msb_out(msb), .data_msb_oe_out(oe), .rd_n_out(rd_n),
		.boot_memory_select_n_out(bms_n), .program_memory_select_n_out(pms_n));
	boot_mem_model mem (.clock_in(clock_in), .addr_in(addr_out), .data_msb_in(msb),
		.rd_n_in(rd_n), .boot_memory_select_n_in(bms_n), .program_memory_select_n_in(pms_n),
		.data_out(mem_data));
	task automatic results();
		if (n_mismatch == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function automatic logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction
	// strobe length, boot pin snapshot and loaded words as seen on the pins
	always @(posedge clock_in) begin
		if (rd_n === 1'b0) begin
			cnt++;
			chk(bms_n & pms_n, 0);
		end else if (cnt != 0) begin
			last_len = cnt;
			cnt = 0;
		end
		if (bms_n === 1'b0) begin
			n_bms++;
			seen_hi = {oe, msb, addr_out[13]};
		end
		if (ram_we === 1'b1) begin
			n_we++;
			if (exp_q.size() == 0)
				chk(1, 0);
			else begin
				chk({ram_addr, ram_wdata}, {11'(BW - exp_q.size()), exp_q[0]});
				void'(exp_q.pop_front());
			end
		end
	end
	task automatic expect_boot(input logic [2:0] pg);
		for (int n = 0; n < BW; n++)
			exp_q.push_back({mem.byte_of({pg, 13'(3 * n)}), mem.byte_of({pg, 13'(3 * n + 1)}),
				mem.byte_of({pg, 13'(3 * n + 2)})});
	endtask
	task automatic do_reset(input logic m, input logic b, input logic r);
		@(negedge clock_in);
		{rst_in, mm, bm, br_n} = {1'b1, m, b, r};
		repeat (12) @(negedge clock_in);
		rst_in = 0;
		n_we = 0;
		n_bms = 0;
	endtask
	task automatic reg_wr(input logic [13:0] a, input logic [15:0] d);
		@(negedge clock_in);
		{we, dma, wd} = {1'b1, a, d};
		@(negedge clock_in);
		we = 0;
	endtask
	task automatic reg_rd(input logic [13:0] a, input logic [15:0] e);
		@(negedge clock_in);
		{re, dma} = {1'b1, a};
		@(negedge clock_in);
		re = 0;
		@(negedge clock_in);
		chk(rdata, e);
	endtask
	task automatic wait_run();
		int i;
		for (i = 0; i < 3000 && run !== 1'b1; i++)
			@(negedge clock_in);
		if (i == 3000) begin
			n_mismatch++;
			results();
		end
		// let the last word pulse reach the pin monitor
		@(negedge clock_in);
	endtask
	task automatic tgt_chk(input logic [13:0] a, input pm_target_t e);
		@(negedge clock_in);
		pma = a;
		@(negedge clock_in);
		chk(tgt, e);
	endtask
	initial begin
		logic [2:0] pg, pw;
		int i;
		// booting page 0, held off by a bus request first
		expect_boot(3'h0);
		do_reset(0, 0, 0);
		repeat (20) @(negedge clock_in);
		chk({n_bms, run}, 0);
		br_n = 1;
		reg_rd(14'h3ffe, 16'h7fff);
		reg_rd(14'h3fff, 16'h03f0);
		reg_rd(14'h1234, 16'h0000);
		wait_run();
		chk({exp_q.size(), last_len, start_addr_out}, {32'd0, 32'd10, 14'h0000});
		chk(seen_hi, 4'h8);
		tgt_chk(14'h0000, TGT_RAM);
		tgt_chk(14'h07ff, TGT_RAM);
		tgt_chk(14'h0800, TGT_EXT);
		tgt_chk(14'h27ff, TGT_EXT);
		reg_wr(14'h3ffe, 16'hffff);
		reg_wr(14'h1234, 16'h0000);
		reg_rd(14'h3ffe, 16'hffff);
		tgt_chk(14'h0800, TGT_ROM);
		tgt_chk(14'h27ff, TGT_ROM);
		tgt_chk(14'h2800, TGT_EXT);
		// software boot from a random page with no boot wait states
		rnd = lfsr(rnd);
		pg = rnd[2:0];
		pw = rnd[5:3];
		expect_boot(pg);
		reg_wr(14'h3fff, {6'h00, pw, 3'h0, 1'b1, pg});
		repeat (3) @(negedge clock_in);
		chk(run, 0);
		wait_run();
		chk({exp_q.size(), last_len, start_addr_out}, {32'd0, 32'd3, 14'h0000});
		chk(seen_hi, {1'b1, pg});
		reg_rd(14'h3fff, {6'h00, pw, 3'h0, 1'b0, pg});
		// external program read with the random wait count
		tgt_chk(14'h3000, TGT_EXT);
		req = 1;
		for (i = 0; i < 100 && ack !== 1'b1; i++)
			@(negedge clock_in);
		req = 0;
		if (i == 100) begin
			n_mismatch++;
			results();
		end
		chk({pm_rdata, 8'(last_len)}, {mem.word_of(14'h3000), 8'(pw + 3)});
		// external map, no boot
		do_reset(1, 0, 1);
		wait_run();
		chk({n_we, n_bms, start_addr_out}, {64'd0, 14'h0000});
		reg_rd(14'h3ffe, 16'h7fff);
		tgt_chk(14'h0000, TGT_EXT);
		tgt_chk(14'h3800, TGT_RAM);
		tgt_chk(14'h3fff, TGT_RAM);
		tgt_chk(14'h0800, TGT_EXT);
		// stand-alone rom
		do_reset(1, 1, 1);
		wait_run();
		chk({n_we, n_bms, start_addr_out}, {64'd0, 14'h0800});
		reg_rd(14'h3ffe, 16'hffff);
		tgt_chk(14'h0800, TGT_ROM);
		// host port boot
		do_reset(0, 1, 1);
		repeat (10) @(negedge clock_in);
		chk({host_req, run, n_bms}, {2'b10, 32'd0});
		hd = 1;
		@(negedge clock_in);
		hd = 0;
		wait_run();
		chk({host_req, start_addr_out}, {1'b0, 14'h0000});
		results();
	end
endmodule
`default_nettype wire
